// [logic/dscr_top.sv]
// Device status, fault recovery and write checksum register bank
// How it works
// - Bits 7 and 6 show channel power
// - Mode field: 4 sleep, 6 idle, 7 active
// - Mode status register resets to 0x80
// - Bit 4 follows boost converter power
// - Bit 3 follows bias supply power
// - Bit 2 flags any input-fault channel shutdown
// - Bit 1 flags bias-fault shutdown of all
// - Writing 1 to bit 0 starts recovery
// - Checksum accumulates every other register write
// - Writing checksum loads the written byte
// - Threshold resets 0x40, live status 0x00
// - Offset zero selects the register page
// - Channel powers only when control and enabled
`timescale 1ns/1ps
module dscr_top
    import dscr_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = 8'h5A  // Arbitrary value
)
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                ce_in,
    input  wire dscr_req_t           req_in,
    input  wire dscr_hw_t            hw_in,
    output logic [7:0]               rd_data_out,
    output logic                     rd_valid_out,
    output logic [CHANNELS-1:0]      channel_run_out,
    output logic                     bias_supply_run_out,
    output logic [7:0]               page_out,
    output logic [7:0]               bias_threshold_out,
    output logic                     recovery_busy_out
);

    // Address match on a given page, used by read and write decode
    function automatic logic hit(input logic [7:0] pg,
                                 input logic [7:0] want_pg,
                                 input logic [7:0] ofs,
                                 input logic [7:0] want_ofs);
        return (pg == want_pg) && (ofs == want_ofs);
    endfunction

    // Configuration registers
    logic [7:0]          page;                // Selected page
    logic [7:0]          next_page;
    logic [7:0]          bias_threshold;      // Overvoltage threshold
    logic [7:0]          next_bias_threshold;

    // Status flops, all read back directly
    logic [CHANNELS-1:0] channel_powered;     // [0] first channel
    logic [CHANNELS-1:0] next_channel_powered;
    logic [2:0]          device_mode_field;
    logic [2:0]          next_device_mode_field;
    logic                boost_powered_flag;
    logic                next_boost_powered_flag;
    logic                bias_supply_powered_flag;
    logic                next_bias_supply_powered_flag;
    logic                input_fault_shutdown_flag;
    logic                next_input_fault_shutdown_flag;
    logic                bias_fault_all_shutdown_flag;
    logic                next_bias_fault_all_shutdown_flag;

    // Fault shutdown latches, held until a recovery re-check
    logic [CHANNELS-1:0] input_shut;
    logic [CHANNELS-1:0] next_input_shut;
    logic                bias_shut;
    logic                next_bias_shut;

    // Recovery sequencer
    dscr_rec_state_t     rec_state;
    dscr_rec_state_t     next_rec_state;
    logic [7:0]          rec_count;
    logic [7:0]          next_rec_count;
    logic                fault_recovery_trigger;
    logic                next_fault_recovery_trigger;
    logic                rec_done;             // Last cycle of re-check

    // Read port
    logic [7:0]          rd_data;
    logic [7:0]          next_rd_data;
    logic                rd_valid;

    // Write decode
    logic                wr_checksum;
    logic                wr_mode_fault;
    logic [7:0]          checksum;
    logic [7:0]          wr_data;

    assign wr_data       = req_in.wdata;
    assign wr_checksum   = req_in.wr &&
        hit(page, PAGE_ZERO, req_in.addr, OFS_CONTROL_WRITE_CHECKSUM);
    assign wr_mode_fault = req_in.wr &&
        hit(page, PAGE_ZERO, req_in.addr, OFS_DEVICE_MODE_FAULT);
    assign rec_done      = (rec_state == REC_RUN) &&
                           (rec_count == COUNT_ZERO);

    // Checksum sees every write except its own load
    dscr_checksum u_checksum (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .load_in  (wr_checksum),
        .accum_in (req_in.wr && !wr_checksum),
        .byte_in  (wr_data),
        .sum_out  (checksum)
    );

    // Page select and page-one threshold; reserved offsets just drop
    always_comb begin
        next_page           = page;
        next_bias_threshold = bias_threshold;
        if (req_in.wr && req_in.addr == OFS_PAGE_SELECT) begin
            next_page = wr_data;
        end
        if (req_in.wr &&
            hit(page, PAGE_ONE, req_in.addr, OFS_BIAS_OVERVOLTAGE)) begin
            next_bias_threshold = wr_data;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            page           <= RST_PAGE_SELECT;
            bias_threshold <= RST_BIAS_OVERVOLTAGE;
        end else if (ce_in) begin
            page           <= next_page;
            bias_threshold <= next_bias_threshold;
        end
    end

    // Recovery: a written 1 runs a fixed re-check, then self-clears
    always_comb begin
        next_rec_state = rec_state;
        next_rec_count = rec_count;
        unique case (rec_state)
            REC_IDLE: begin
                // A written 0 has no effect; a 1 starts the re-check
                if (wr_mode_fault && wr_data[BIT_RECOVERY]) begin
                    next_rec_state = REC_RUN;
                    next_rec_count = RECOVERY_LAST;
                end
            end
            REC_RUN: begin
                // Writes during the re-check are not queued
                if (rec_count == COUNT_ZERO) begin
                    next_rec_state = REC_IDLE;
                end else begin
                    next_rec_count = 8'(rec_count - COUNT_ONE);
                end
            end
            default: begin
                next_rec_state = REC_IDLE;
                next_rec_count = COUNT_ZERO;
            end
        endcase
        next_fault_recovery_trigger = (next_rec_state == REC_RUN);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rec_state              <= REC_IDLE;
            rec_count              <= COUNT_ZERO;
            fault_recovery_trigger <= 1'b0;
        end else if (ce_in) begin
            rec_state              <= next_rec_state;
            rec_count              <= next_rec_count;
            fault_recovery_trigger <= next_fault_recovery_trigger;
        end
    end

    // Fault latches and status; a live fault beats the recovery clear
    always_comb begin
        next_input_shut = input_shut;
        next_bias_shut  = bias_shut;
        for (int i = 0; i < CHANNELS; i++) begin
            if (rec_done) begin
                next_input_shut[i] = hw_in.input_fault[i];
            end else if (hw_in.input_fault[i]) begin
                next_input_shut[i] = 1'b1;
            end
        end
        if (rec_done) begin
            next_bias_shut = hw_in.bias_fault;
        end else if (hw_in.bias_fault) begin
            next_bias_shut = 1'b1;
        end
        // Power needs the control bit, the enable and no fault
        for (int i = 0; i < CHANNELS; i++) begin
            next_channel_powered[i] = hw_in.converter_power_control &&
                hw_in.chan_enable[i] && !hw_in.sleep_mode &&
                !next_input_shut[i] && !next_bias_shut;
        end
        if (hw_in.sleep_mode) begin
            next_device_mode_field = MODE_SLEEP;
        end else if (|next_channel_powered) begin
            next_device_mode_field = MODE_ACTIVE;
        end else begin
            next_device_mode_field = MODE_IDLE;
        end
        next_boost_powered_flag           = hw_in.boost_powered;
        next_bias_supply_powered_flag     = hw_in.bias_power_control &&
            !hw_in.sleep_mode && !next_bias_shut;
        next_input_fault_shutdown_flag    = |next_input_shut;
        next_bias_fault_all_shutdown_flag = next_bias_shut;
    end

    // Status bits track hardware; host writes reach them only through the recovery re-check that clears the fault latches
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            input_shut                   <= '0;
            bias_shut                    <= 1'b0;
            channel_powered              <= '0;
            device_mode_field            <= MODE_SLEEP;
            boost_powered_flag           <= 1'b0;
            bias_supply_powered_flag     <= 1'b0;
            input_fault_shutdown_flag    <= 1'b0;
            bias_fault_all_shutdown_flag <= 1'b0;
        end else if (ce_in) begin
            input_shut                   <= next_input_shut;
            bias_shut                    <= next_bias_shut;
            channel_powered              <= next_channel_powered;
            device_mode_field            <= next_device_mode_field;
            boost_powered_flag           <= next_boost_powered_flag;
            bias_supply_powered_flag     <= next_bias_supply_powered_flag;
            input_fault_shutdown_flag    <= next_input_fault_shutdown_flag;
            bias_fault_all_shutdown_flag <=
                next_bias_fault_all_shutdown_flag;
        end
    end

    // Read mux; unmapped and live diagnostic offsets read zero
    always_comb begin
        next_rd_data = RST_LIVE_STATUS;
        if (req_in.addr == OFS_PAGE_SELECT) begin
            next_rd_data = page;
        end else if (hit(page, PAGE_ZERO, req_in.addr,
                         OFS_CHANNEL_POWER_STATUS)) begin
            next_rd_data[BIT_FIRST_CHANNEL]  = channel_powered[0];
            next_rd_data[BIT_SECOND_CHANNEL] = channel_powered[1];
        end else if (hit(page, PAGE_ZERO, req_in.addr,
                         OFS_DEVICE_MODE_FAULT)) begin
            next_rd_data[BIT_MODE_HI:BIT_MODE_LO] = device_mode_field;
            next_rd_data[BIT_BOOST_POWERED]  = boost_powered_flag;
            next_rd_data[BIT_BIAS_POWERED]   = bias_supply_powered_flag;
            next_rd_data[BIT_INPUT_FAULT]    = input_fault_shutdown_flag;
            next_rd_data[BIT_BIAS_FAULT_ALL] = bias_fault_all_shutdown_flag;
            next_rd_data[BIT_RECOVERY]       = fault_recovery_trigger;
        end else if (hit(page, PAGE_ZERO, req_in.addr,
                         OFS_CONTROL_WRITE_CHECKSUM)) begin
            next_rd_data = checksum;
        end else if (hit(page, PAGE_ONE, req_in.addr,
                         OFS_BIAS_OVERVOLTAGE)) begin
            next_rd_data = bias_threshold;
        end else if (hit(page, PAGE_ONE, req_in.addr,
                         OFS_SILICON_REVISION)) begin
            next_rd_data = SILICON_REVISION;
        end
    end

    // Read data is held until the next read strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data  <= RST_READ_DATA;
            rd_valid <= 1'b0;
        end else if (ce_in) begin
            rd_valid <= req_in.rd;
            if (req_in.rd) begin
                rd_data <= next_rd_data;
            end
        end
    end

    assign rd_data_out         = rd_data;
    assign rd_valid_out        = rd_valid;
    assign channel_run_out     = channel_powered;
    assign bias_supply_run_out = bias_supply_powered_flag;
    assign page_out            = page;
    assign bias_threshold_out  = bias_threshold;
    assign recovery_busy_out   = fault_recovery_trigger;

    // Checks on the behaviour above
    localparam int A_REC_MAX = 1000;
    logic [7:0] a_status1;
    assign a_status1 = {device_mode_field, boost_powered_flag,
        bias_supply_powered_flag, input_fault_shutdown_flag,
        bias_fault_all_shutdown_flag, fault_recovery_trigger};

    default clocking a_cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_chan_power_off: assert property (
        ce_in && !hw_in.converter_power_control |=> channel_powered == '0)
        else $error("channel powered without power control");
    a_mode_sleep_code: assert property (
        ce_in && hw_in.sleep_mode |=> device_mode_field == 3'h4)
        else $error("sleep mode code wrong");
    a_mode_active_code: assert property (
        ce_in && !hw_in.sleep_mode |=>
        device_mode_field == ((|channel_powered) ? 3'h7 : 3'h6))
        else $error("active mode code wrong");
    a_status_reset_value: assert property (
        $fell(rst_in) |-> a_status1 == 8'h80 && channel_powered == '0)
        else $error("status reset value wrong");
    a_boost_flag_follow: assert property (
        ce_in |=> boost_powered_flag == $past(hw_in.boost_powered))
        else $error("boost flag does not follow");
    a_bias_flag_off: assert property (
        ce_in && !hw_in.bias_power_control |=> !bias_supply_powered_flag)
        else $error("bias flag set while powered down");
    a_input_fault_flag: assert property (
        ce_in && (|hw_in.input_fault) |=> input_fault_shutdown_flag)
        else $error("input fault not flagged");
    a_bias_fault_all: assert property (
        ce_in && hw_in.bias_fault |=>
        bias_fault_all_shutdown_flag && channel_powered == '0)
        else $error("bias fault did not shut all channels");
    a_recovery_start: assert property (
        ce_in && !fault_recovery_trigger && wr_mode_fault &&
        wr_data[0] |=> fault_recovery_trigger)
        else $error("recovery did not start");
    a_recovery_zero_write: assert property (
        ce_in && !fault_recovery_trigger && wr_mode_fault &&
        !wr_data[0] |=> !fault_recovery_trigger)
        else $error("zero write started recovery");
    a_recovery_self_clear: assert property (
        $rose(fault_recovery_trigger) |-> ##[1:A_REC_MAX]
        !fault_recovery_trigger)
        else $error("recovery trigger never cleared");
    a_checksum_load: assert property (
        ce_in && wr_checksum |=> checksum == $past(wr_data))
        else $error("checksum load wrong");
    a_checksum_accum: assert property (
        ce_in && req_in.wr && !wr_checksum |=>
        checksum == 8'($past(checksum) + $past(wr_data)))
        else $error("checksum accumulate wrong");
    a_threshold_reset: assert property (
        $fell(rst_in) |-> bias_threshold == 8'h40)
        else $error("threshold reset value wrong");
    a_page_select_write: assert property (
        ce_in && req_in.wr && req_in.addr == 8'h00 |=>
        page == $past(wr_data))
        else $error("page select not loaded");

    c_recovery_run: cover property (
        $rose(fault_recovery_trigger) ##[1:20] $fell(fault_recovery_trigger));
    c_checksum_load: cover property (ce_in && wr_checksum);
    c_bias_fault_shut: cover property ($rose(bias_fault_all_shutdown_flag));
    c_channel_active: cover property (device_mode_field == 3'h7);

endmodule

// [include/dscr_pkg.sv]
// Constants, carriers and register map for the status and checksum bank
package dscr_pkg;

    // Page numbers and register offsets
    localparam logic [7:0] PAGE_ZERO                  = 8'h00;
    localparam logic [7:0] PAGE_ONE                   = 8'h01;
    localparam logic [7:0] OFS_PAGE_SELECT            = 8'h00;
    localparam logic [7:0] OFS_CHANNEL_POWER_STATUS   = 8'h76;
    localparam logic [7:0] OFS_DEVICE_MODE_FAULT      = 8'h77;
    localparam logic [7:0] OFS_CONTROL_WRITE_CHECKSUM = 8'h7E;
    localparam logic [7:0] OFS_BIAS_OVERVOLTAGE       = 8'h55;
    localparam logic [7:0] OFS_SILICON_REVISION       = 8'h7E;

    // Field positions
    localparam int BIT_FIRST_CHANNEL   = 7;
    localparam int BIT_SECOND_CHANNEL  = 6;
    localparam int BIT_MODE_HI         = 7;
    localparam int BIT_MODE_LO         = 5;
    localparam int BIT_BOOST_POWERED   = 4;
    localparam int BIT_BIAS_POWERED    = 3;
    localparam int BIT_INPUT_FAULT     = 2;
    localparam int BIT_BIAS_FAULT_ALL  = 1;
    localparam int BIT_RECOVERY        = 0;

    // Reset values
    localparam logic [7:0] RST_PAGE_SELECT      = 8'h00;
    localparam logic [7:0] RST_CHECKSUM         = 8'h00;
    localparam logic [7:0] RST_BIAS_OVERVOLTAGE = 8'h40;
    localparam logic [7:0] RST_READ_DATA        = 8'h00;
    localparam logic [7:0] RST_LIVE_STATUS      = 8'h00;
    localparam logic [7:0] RST_MODE_FAULT       = 8'h80;

    // Device mode codes
    localparam logic [2:0] MODE_SLEEP  = 3'h4;
    localparam logic [2:0] MODE_IDLE   = 3'h6;
    localparam logic [2:0] MODE_ACTIVE = 3'h7;

    // Channel count
    localparam int CHANNELS = 2;

    // Timing: recovery re-check lasts a fixed least time
    localparam int CLK_PERIOD_NS    = 100;
    localparam int RECOVERY_TIME_NS = 1000;
    localparam int RECOVERY_CYCLES_INT =
        (RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RECOVERY_LAST = 8'(RECOVERY_CYCLES_INT - 1);
    localparam logic [7:0] COUNT_ZERO    = 8'h00;
    localparam logic [7:0] COUNT_ONE     = 8'h01;

    // Register access request, one per cycle
    typedef struct packed {
        logic       wr;     // Write strobe
        logic       rd;     // Read strobe
        logic [7:0] addr;   // Offset within the current page
        logic [7:0] wdata;  // Write byte
    } dscr_req_t;

    // Live hardware levels that feed the status bits
    typedef struct packed {
        logic                converter_power_control;
        logic [CHANNELS-1:0] chan_enable;     // [0] is the first channel
        logic                sleep_mode;
        logic                boost_powered;
        logic                bias_power_control;
        logic [CHANNELS-1:0] input_fault;     // Per-channel pin fault
        logic                bias_fault;
    } dscr_hw_t;

    // Recovery sequencer states
    typedef enum logic [1:0] {
        REC_IDLE = 2'b01,
        REC_RUN  = 2'b10
    } dscr_rec_state_t;

endpackage

// [logic/dscr_checksum.sv]
// Running checksum over control writes, loadable by the host
`timescale 1ns/1ps
module dscr_checksum
    import dscr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       load_in,
    input  wire logic       accum_in,
    input  wire logic [7:0] byte_in,
    output logic      [7:0] sum_out
);

    logic [7:0] sum;       // Current checksum
    logic [7:0] next_sum;  // Value after this cycle

    // Load wins over accumulate; they never coincide from the top
    always_comb begin
        next_sum = sum;
        if (load_in) begin
            next_sum = byte_in;
        end else if (accum_in) begin
            next_sum = 8'(sum + byte_in);
        end
    end

    // Register only; clock enable freezes the sum
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sum <= RST_CHECKSUM;
        end else if (ce_in) begin
            sum <= next_sum;
        end
    end

    assign sum_out = sum;

endmodule

// [tb/tb.sv]
// Self-checking bench for the status, recovery and checksum bank
`timescale 1ns/1ps
module tb;
    import dscr_pkg::*;
    localparam logic [7:0] REV = 8'h3C;  // Arbitrary revision value
    logic        clk_in = 1'b0;           // Bench clock, 100 ns
    logic        rst_in = 1'b1;           // Async reset, held 3 cycles
    logic        ce_in  = 1'b1;           // Bank enabled except in the clock enable freeze check
    dscr_req_t   req    = '0;             // Register request
    dscr_hw_t    hw     = '0;             // Live hardware levels
    logic [7:0]  rd_data_out;
    logic        rd_valid_out;
    logic [1:0]  channel_run_out;
    logic        bias_supply_run_out;
    logic [7:0]  page_out;
    logic [7:0]  bias_threshold_out;
    logic        recovery_busy_out;
    logic [15:0] exp_q[$];                // Pending reads: offset, value
    logic [15:0] note;                    // Oldest pending read
    logic [7:0]  cks = 8'h00;             // Checksum model
    logic [7:0]  pg  = 8'h00;             // Page model
    logic [31:0] seed = 32'hD69DBA10;     // Xorshift state
    logic [1:0]  on;                      // Expected powered channels
    logic        bon;                     // Expected bias supply power
    int          fail_count = 0;
    int          samples_checked = 0;

    dscr_top #(.SILICON_REVISION(REV)) dscr_top_inst (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
        .hw_in(hw), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .channel_run_out(channel_run_out),
        .bias_supply_run_out(bias_supply_run_out), .page_out(page_out),
        .bias_threshold_out(bias_threshold_out),
        .recovery_busy_out(recovery_busy_out));

    always #50 clk_in = ~clk_in;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One write; the model mirrors the old-page decode of the bank
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{1'b1, 1'b0, a, d};            // Write, no read
        if (pg == PAGE_ZERO && a == OFS_CONTROL_WRITE_CHECKSUM) cks = d;
        else cks = cks + d;
        if (a == OFS_PAGE_SELECT) pg = d;
        @(posedge clk_in);
        req <= '0;
    endtask

    // One read; the expected byte is noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        req <= '{1'b0, 1'b1, a, 8'h00};        // Read, no write
        exp_q.push_back({a, e});
        @(posedge clk_in);
        req <= '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Host sequence around a recovery; s1 is the status before it
    task automatic recover(input logic [7:0] s1);
        wr(8'h3A, 8'h00);                      // location 58 cleared
        wr(OFS_DEVICE_MODE_FAULT, 8'h01);
        rd(OFS_DEVICE_MODE_FAULT, s1 | 8'h01); // trigger set meanwhile
        chk("recovery_busy_out", 8'(recovery_busy_out), 8'h01);
        idle(12);
        chk("recovery_busy_out", 8'(recovery_busy_out), 8'h00);
        wr(8'h3A, 8'h0F);                      // restored after it
    endtask

    // Watcher: each answer is paired with the oldest note
    always @(posedge clk_in) begin
        if (rd_valid_out === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
            chk("rd_data_out", rd_data_out, note[7:0]);
        end
    end

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs well under 3000 cycles
    initial begin
        #(3000 * 100);
        fail_count++;
        stop_test();
    end

    initial begin
        hw.sleep_mode = 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        chk("bias_threshold_out", bias_threshold_out, 8'h40);
        rd(OFS_CHANNEL_POWER_STATUS, 8'h00);
        rd(OFS_DEVICE_MODE_FAULT, 8'h80);
        rd(OFS_CONTROL_WRITE_CHECKSUM, 8'h00);
        // Random power levels; writes to status must not stick
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            hw <= '{seed[0], seed[2:1], seed[3], seed[4], seed[5],
                    2'b00, 1'b0};
            on = (seed[0] && !seed[3]) ? seed[2:1] : 2'b00;
            bon = seed[5] & ~seed[3];
            wr(OFS_CHANNEL_POWER_STATUS, seed[31:24]);
            wr(OFS_DEVICE_MODE_FAULT, seed[23:16] & 8'hFE);
            idle(1);
            rd(OFS_CHANNEL_POWER_STATUS, {on[0], on[1], 6'h00});
            rd(OFS_DEVICE_MODE_FAULT, {seed[3] ? MODE_SLEEP : (|on ?
                MODE_ACTIVE : MODE_IDLE), seed[4], bon, 3'b000});
            chk("channel_run_out", 8'(channel_run_out), 8'(on));
            chk("bias_supply_run_out", 8'(bias_supply_run_out),
                8'(bon));
        end
        rd(OFS_CONTROL_WRITE_CHECKSUM, cks);
        wr(OFS_CONTROL_WRITE_CHECKSUM, 8'hA5);
        rd(OFS_CONTROL_WRITE_CHECKSUM, 8'hA5);
        wr(8'h3A, 8'h11);
        rd(OFS_CONTROL_WRITE_CHECKSUM, cks);
        // Page one: only listed offsets are written
        wr(OFS_PAGE_SELECT, PAGE_ONE);
        idle(1);
        chk("page_out", page_out, PAGE_ONE);
        rd(OFS_BIAS_OVERVOLTAGE, 8'h40);
        rd(8'h2C, 8'h00);
        rd(OFS_SILICON_REVISION, REV);
        wr(OFS_BIAS_OVERVOLTAGE, 8'h3C);
        rd(OFS_BIAS_OVERVOLTAGE, 8'h3C);
        chk("bias_threshold_out", bias_threshold_out, 8'h3C);
        wr(OFS_PAGE_SELECT, PAGE_ZERO);
        rd(OFS_CONTROL_WRITE_CHECKSUM, cks);
        // Input fault on the first channel, gone before recovery
        hw <= '{1'b1, 2'b11, 1'b0, 1'b1, 1'b1, 2'b01, 1'b0};
        idle(3);
        hw.input_fault <= 2'b00;
        idle(3);
        rd(OFS_CHANNEL_POWER_STATUS, 8'h40);
        rd(OFS_DEVICE_MODE_FAULT, 8'hFC);
        recover(8'hFC);
        rd(OFS_CHANNEL_POWER_STATUS, 8'hC0);
        rd(OFS_DEVICE_MODE_FAULT, 8'hF8);
        // Bias fault: recovery while present keeps the shutdown
        hw.bias_fault <= 1'b1;
        idle(3);
        rd(OFS_CHANNEL_POWER_STATUS, 8'h00);
        rd(OFS_DEVICE_MODE_FAULT, 8'hD2);
        recover(8'hD2);
        rd(OFS_DEVICE_MODE_FAULT, 8'hD2);
        hw.bias_fault <= 1'b0;
        recover(8'hD2);
        rd(OFS_DEVICE_MODE_FAULT, 8'hF8);
        // Clock enable low freezes status; let the last answer pass first
        idle(2);
        ce_in <= 1'b0;
        hw.sleep_mode <= 1'b1;
        idle(3);
        chk("channel_run_out", 8'(channel_run_out), 8'h03);
        ce_in <= 1'b1;
        idle(2);
        chk("channel_run_out", 8'(channel_run_out), 8'h00);
        rd(OFS_CONTROL_WRITE_CHECKSUM, cks);
        idle(3);
        chk("pending reads", 8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
